// >>> core/tas_sensor.sv
// Thermal alert sensor: two-wire slave, register file and open-drain alert output.
// Assumes an external pull-up on the data and alert lines and a host driving the serial clock.
// Functional notes
// - Configuration bit 2 picks alert asserted level: 1 high, 0 low; resets 0.
// - Configuration bit 1 picks latched interrupt (1) or comparator (0); resets 0.
// - Comparator asserts above upper threshold, releases only below hysteresis threshold.
// - In comparator behaviour reads and shutdown entry leave the alert untouched.
// - Interrupt fires on either crossing and holds until a read or shutdown.
// - Trips are judged per conversion; alert moves after enough consecutive trips.
// - Bits 4:3 give needed trip count: 00=1, 01=2, 10=4, 11=6.
// - Configuration bit 0 selects shutdown (1) or periodic conversion (0).
// - Shutdown stops conversions while every register stays readable and all but the temperature register writable.
// - Power-up: normal, comparator, active low, 80 C, 75 C, pointer zero.
// - Each byte takes nine host clocks: eight data bits plus acknowledge.
// - Data line changes only while clock is low, outside start and stop.
// - Host releases data in device acknowledge slots; device pulls low.
// - In two-byte reads host acknowledges first byte; device sends second.
// - After the last read byte both sides release data as not-acknowledge.
// - Configuration transfers carry one byte; threshold and temperature transfers two.
// - A read without pointer byte uses the last written or default pointer.
// - Only the nine upper temperature bits are compared, signed, against limits.
// - The temperature register is read-only and reloaded after each conversion.
`timescale 1ns/1ns
`include "tas_params.svh"
module tas_sensor import tas_pkg::*; #(
	parameter int CONV_CYCLES = `TAS_CONV_TIME_NS / `TAS_CLK_PERIOD_NS,
	parameter logic [3:0] ADDR_HIGH = `TAS_ADDR_HIGH,
	parameter logic [7:0] PTR_TEMP = `TAS_PTR_TEMP,
	parameter logic [7:0] PTR_CONF = `TAS_PTR_CONF,
	parameter logic [7:0] PTR_THYST = `TAS_PTR_THYST,
	parameter logic [7:0] PTR_TOS = `TAS_PTR_TOS
)(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address select pins
	input wire logic [2:0] addr_sel_i,
	// Converter result
	input wire tas_temp_t temp_sample_i,
	// Open-drain over-temperature alert
	output logic overtemp_alert_output_o,
	output logic overtemp_alert_output_oe_o
);
	tas_alert_if aif ();

	tas_state_e state_q;
	logic [4:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic [2:0] addr_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic rw_q;
	logic [1:0] idx_q;
	logic [1:0] idx_next;
	logic [7:0] tx_first;
	logic [7:0] tx_next;
	logic sda_drv_q;
	logic rd_evt_q;
	logic wr_strobe;
	logic addr_hit;
	logic [7:0] ptr_q;
	logic [7:0] conf_q;
	logic [7:0] hold_q;
	tas_limit_t tos_q;
	tas_limit_t thyst_q;
	logic alert_oe_q;

	// ==========================================================
	// Pin synchronisation and bus conditions
	tas_sync #(
		.WIDTH(5),
		.RST_VAL(5'h1f)
	) u_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.d_i({addr_sel_i, sda_i, scl_i}),
		.q_o(pin_s)
	);

	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];
	assign addr_s = pin_s[4:2];

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	// Data moving while the clock stays high is a start or a stop, never data.
	assign start_evt = scl_s && scl_q && sda_q && !sda_s;
	assign stop_evt = scl_s && scl_q && !sda_q && sda_s;
	assign addr_hit = (shift_q[7:1] == {ADDR_HIGH, addr_s});
	assign idx_next = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;

	// ==========================================================
	// Read data selection
	function automatic logic [7:0] tas_tx_byte(input logic [7:0] ptr, input logic [1:0] idx);
		logic [15:0] word;
		word = 16'h0000;
		if (ptr == PTR_TEMP) begin
			word = {aif.temp, 5'h00};
		end else if (ptr == PTR_CONF) begin
			word = {conf_q, 8'h00};
		end else if (ptr == PTR_TOS) begin
			word = {tos_q, 7'h00};
		end else if (ptr == PTR_THYST) begin
			word = {thyst_q, 7'h00};
		end
		case (idx)
			2'h0: tas_tx_byte = word[15:8];
			2'h1: tas_tx_byte = word[7:0];
			default: tas_tx_byte = 8'h00;
		endcase
	endfunction

	assign tx_first = tas_tx_byte(ptr_q, 2'h0);
	assign tx_next = tas_tx_byte(ptr_q, idx_next);

	// ==========================================================
	// Serial slave engine
	// Outgoing bits change only on a falling clock so the line is steady while high.
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state_q <= st_idle;
			bit_q <= '0;
			shift_q <= '0;
			rw_q <= 1'b0;
			idx_q <= '0;
			sda_drv_q <= 1'b0;
		end else if (start_evt) begin
			state_q <= st_addr;
			bit_q <= '0;
			sda_drv_q <= 1'b0;
		end else if (stop_evt) begin
			state_q <= st_idle;
			sda_drv_q <= 1'b0;
		end else begin
			case (state_q)
				st_idle: begin
					sda_drv_q <= 1'b0;
				end
				st_addr, st_write: begin
					if (scl_rise && bit_q != 4'h8) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						if (state_q == st_write) begin
							state_q <= st_wack;
							sda_drv_q <= 1'b1;
						end else if (addr_hit) begin
							state_q <= st_aack;
							rw_q <= shift_q[0];
							sda_drv_q <= 1'b1;
						end else begin
							state_q <= st_idle;
						end
					end
				end
				st_aack: begin
					if (scl_fall) begin
						bit_q <= '0;
						idx_q <= '0;
						if (rw_q) begin
							state_q <= st_read;
							shift_q <= tx_first;
							sda_drv_q <= ~tx_first[7];
						end else begin
							state_q <= st_write;
							sda_drv_q <= 1'b0;
						end
					end
				end
				st_wack: begin
					if (scl_fall) begin
						state_q <= st_write;
						bit_q <= '0;
						idx_q <= idx_next;
						sda_drv_q <= 1'b0;
					end
				end
				st_read: begin
					if (scl_rise) begin
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall) begin
						if (bit_q == 4'h8) begin
							state_q <= st_rack;
							sda_drv_q <= 1'b0;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sda_drv_q <= ~shift_q[6];
						end
					end
				end
				st_rack: begin
					if (scl_rise) begin
						if (sda_s) begin
							state_q <= st_idle;
						end else begin
							bit_q <= '0;
						end
					end else if (scl_fall && bit_q == 4'h0) begin
						state_q <= st_read;
						idx_q <= idx_next;
						shift_q <= tx_next;
						sda_drv_q <= ~tx_next[7];
					end
				end
				default: begin
					state_q <= st_idle;
					sda_drv_q <= 1'b0;
				end
			endcase
		end
	end

	// A read of any register starts when a matching read address is accepted.
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rd_evt_q <= 1'b0;
		end else begin
			rd_evt_q <= !start_evt && !stop_evt && state_q == st_addr && scl_fall
				&& bit_q == 4'h8 && addr_hit && shift_q[0];
		end
	end

	// ==========================================================
	// Register file
	assign wr_strobe = !start_evt && !stop_evt && state_q == st_write && scl_fall && bit_q == 4'h8;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			ptr_q <= `TAS_PTR_RST;
			conf_q <= `TAS_CONF_RST;
			hold_q <= 8'h00;
			tos_q <= `TAS_TOS_RST;
			thyst_q <= `TAS_THYST_RST;
		end else if (wr_strobe) begin
			if (idx_q == 2'h0) begin
				ptr_q <= shift_q;
			end else if (idx_q == 2'h1 && ptr_q == PTR_CONF) begin
				conf_q <= shift_q;
			end else if (idx_q == 2'h1) begin
				hold_q <= shift_q;
			end else if (idx_q == 2'h2 && ptr_q == PTR_TOS) begin
				tos_q <= {hold_q, shift_q[7]};
			end else if (idx_q == 2'h2 && ptr_q == PTR_THYST) begin
				thyst_q <= {hold_q, shift_q[7]};
			end
		end
	end

	assign aif.conf = conf_q;
	assign aif.tos = tos_q;
	assign aif.thyst = thyst_q;
	assign aif.rd_evt = rd_evt_q;

	// ==========================================================
	// Alert monitor
	tas_alert #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_alert (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.temp_sample_i(temp_sample_i),
		.bus(aif.mon)
	);

	// ==========================================================
	// Pin drivers
	// The alert pin can only sink, so a high asserted level means releasing it.
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			alert_oe_q <= 1'b0;
		end else begin
			alert_oe_q <= aif.alert_active ^ conf_q[`TAS_CONF_POLARITY];
		end
	end

	assign overtemp_alert_output_o = 1'b0;
	assign overtemp_alert_output_oe_o = alert_oe_q;
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_drv_q;
endmodule

// >>> core/tas_params.svh
// Constants of the thermal alert sensor: field positions, reset values, pointer codes and timing.
// Included by every file that needs a figure; holds definitions only.
`ifndef TAS_PARAMS_SVH
`define TAS_PARAMS_SVH

// ==========================================================
// Configuration register fields
`define TAS_CONF_SHUTDOWN 0
`define TAS_CONF_INT_MODE 1
`define TAS_CONF_POLARITY 2
`define TAS_CONF_FQ_LO 3
`define TAS_CONF_FQ_HI 4
`define TAS_CONF_RST 8'h00

// ==========================================================
// Power-up values: 80 C and 75 C in half-degree steps, pointer zero
`define TAS_TOS_RST 9'h0a0
`define TAS_THYST_RST 9'h096
`define TAS_PTR_RST 8'h00

// ==========================================================
// Pointer codes of the registers (arbitrary defaults)
`define TAS_PTR_TEMP 8'h00
`define TAS_PTR_CONF 8'h01
`define TAS_PTR_THYST 8'h02
`define TAS_PTR_TOS 8'h03

// ==========================================================
// Slave address upper bits (arbitrary default), fault counts
`define TAS_ADDR_HIGH 4'h4
`define TAS_FQ_00 3'h1
`define TAS_FQ_01 3'h2
`define TAS_FQ_10 3'h4
`define TAS_FQ_11 3'h6

// ==========================================================
// Timing: conversion interval in ns and clock period in ns
`define TAS_CONV_TIME_NS 100000
`define TAS_CLK_PERIOD_NS 10

`endif

// >>> core/tas_pkg.sv
// Types shared by the thermal alert sensor modules.
// Assumes nothing of its surroundings.
package tas_pkg;

	// ==========================================================
	// Serial slave states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_addr = 3'b001,
		st_aack = 3'b010,
		st_write = 3'b011,
		st_wack = 3'b100,
		st_read = 3'b101,
		st_rack = 3'b110
	} tas_state_e;

	typedef logic [8:0] tas_limit_t;
	typedef logic [10:0] tas_temp_t;

endpackage

// >>> core/tas_alert_if.sv
// Carrier between the register side and the alert monitor of the sensor.
// Both ends run on the same clock.
`timescale 1ns/1ns
interface tas_alert_if;
	import tas_pkg::*;
	logic [7:0] conf;
	tas_limit_t tos;
	tas_limit_t thyst;
	tas_temp_t temp;
	logic rd_evt;
	logic alert_active;

	modport regs (
		output conf,
		output tos,
		output thyst,
		output rd_evt,
		input temp,
		input alert_active
	);

	modport mon (
		input conf,
		input tos,
		input thyst,
		input rd_evt,
		output temp,
		output alert_active
	);
endinterface

// >>> core/tas_sync.sv
// Three-stage synchroniser for pins arriving from outside the clock domain.
// A change is taken once the second and third stages agree.
`timescale 1ns/1ns
module tas_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
)(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Each bit filters on its own so a glitch on one pin never holds another.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk_i) begin
			if (!nrst_i) begin
				q_o[i] <= RST_VAL[i];
			end else if (s2_q[i] == s3_q[i]) begin
				q_o[i] <= s3_q[i];
			end
		end
	end
endmodule

// >>> core/tas_alert.sv
// Conversion timing, temperature register and over-temperature alert state.
// Takes converter samples on the same clock; settings arrive over the alert carrier.
`timescale 1ns/1ns
`include "tas_params.svh"
module tas_alert import tas_pkg::*; #(
	parameter int CONV_CYCLES = `TAS_CONV_TIME_NS / `TAS_CLK_PERIOD_NS
)(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Converter result
	input wire tas_temp_t temp_sample_i,
	// Register side
	tas_alert_if.mon bus
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	logic [CW-1:0] tick_q;
	logic shutdown;
	logic conv_done;
	logic hot_q;
	logic latch_q;
	logic shut_q;
	logic [2:0] cnt_q;
	logic [2:0] need;
	logic trip;
	logic fire;
	tas_limit_t t9;

	function automatic logic [2:0] tas_fault_need(input logic [1:0] code);
		case (code)
			2'b00: tas_fault_need = `TAS_FQ_00;
			2'b01: tas_fault_need = `TAS_FQ_01;
			2'b10: tas_fault_need = `TAS_FQ_10;
			default: tas_fault_need = `TAS_FQ_11;
		endcase
	endfunction

	// ==========================================================
	// Conversion timer
	assign shutdown = bus.conf[`TAS_CONF_SHUTDOWN];
	assign conv_done = !shutdown && (tick_q == CW'(CONV_CYCLES - 1));

	always_ff @(posedge mclk_i) begin
		if (!nrst_i || shutdown) begin
			tick_q <= '0;
		end else if (conv_done) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			bus.temp <= '0;
		end else if (conv_done) begin
			bus.temp <= temp_sample_i;
		end
	end

	// ==========================================================
	// Trip detection and fault queue
	// The hot flag decides which limit is watched, so both modes see the same hysteresis.
	assign t9 = temp_sample_i[10:2];
	assign trip = hot_q ? ($signed(t9) < $signed(bus.thyst)) : ($signed(t9) > $signed(bus.tos));
	assign need = tas_fault_need(bus.conf[`TAS_CONF_FQ_HI:`TAS_CONF_FQ_LO]);
	assign fire = conv_done && trip && ((cnt_q + 3'h1) >= need);

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			hot_q <= 1'b0;
		end else if (conv_done) begin
			if (fire) begin
				cnt_q <= '0;
				hot_q <= ~hot_q;
			end else if (trip) begin
				cnt_q <= cnt_q + 3'h1;
			end else begin
				cnt_q <= '0;
			end
		end
	end

	// ==========================================================
	// Latched interrupt state
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			shut_q <= 1'b0;
		end else begin
			shut_q <= shutdown;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			latch_q <= 1'b0;
		end else if (fire) begin
			latch_q <= 1'b1;
		end else if (bus.rd_evt || (shutdown && !shut_q)) begin
			latch_q <= 1'b0;
		end
	end

	// Comparator behaviour ignores reads and shutdown entry entirely.
	assign bus.alert_active = bus.conf[`TAS_CONF_INT_MODE] ? latch_q : hot_q;
endmodule

// >>> verification/tas_sensor_sva.sv
// Checker of the sensor's pin behaviour, bound to the top module.
// Sees only the top module's ports; the bench resolves the open-drain wires.
`timescale 1ns/1ns
module tas_sensor_sva import tas_pkg::*; (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Address and converter
	input wire logic [2:0] addr_sel_i,
	input wire tas_temp_t temp_sample_i,
	// Alert pin
	input wire logic overtemp_alert_output_o,
	input wire logic overtemp_alert_output_oe_o
);
	// ==========
	// Bus conditions
	default clocking cb @(posedge mclk_i);
	endclocking
	sequence start_s;
		scl_i && sda_i ##1 scl_i && !sda_i;
	endsequence
	sequence stop_s;
		scl_i && !sda_i ##1 scl_i && sda_i;
	endsequence

	// ==========
	// Pin checks
	// The reset checks carry no disable, since reset is their cause.
	drive_zero_a: assert property (disable iff (!nrst_i) sda_o == 1'b0)
		else $error("data line output value not zero");
	alert_zero_a: assert property (disable iff (!nrst_i) overtemp_alert_output_o == 1'b0)
		else $error("alert output value not zero");
	reset_sda_a: assert property (!nrst_i |=> !sda_oe_o)
		else $error("data line driven after reset");
	reset_alert_a: assert property (!nrst_i |=> !overtemp_alert_output_oe_o)
		else $error("alert pulled after reset");
	sda_steady_a: assert property (disable iff (!nrst_i) $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("data drive changed while clock high");
	ack_late_a: assert property (disable iff (!nrst_i) $rose(sda_oe_o) |-> !$past(scl_i, 3))
		else $error("data drive began too soon after clock fall");
	start_idle_a: assert property (disable iff (!nrst_i) start_s |=> !sda_oe_o [*8])
		else $error("data driven right after start");
	stop_idle_a: assert property (disable iff (!nrst_i) stop_s |=> !sda_oe_o [*8])
		else $error("data driven right after stop");
endmodule

bind tas_sensor tas_sensor_sva i_tas_sensor_sva (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
	.temp_sample_i(temp_sample_i), .overtemp_alert_output_o(overtemp_alert_output_o),
	.overtemp_alert_output_oe_o(overtemp_alert_output_oe_o));

// >>> verification/tas_i2c_host.sv
// Host controller model that bit-bangs the two-wire bus.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ns
module tas_i2c_host (
	// Clock
	input wire logic mclk_i,
	// Bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// ==========
	// Bus phases
	// Data bits run at an 80 ns period, two system clocks high and six low.
	// The device answers about five clocks after a fall, so the long low phase keeps its data steady while high.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	// Also serves as repeated start: data is released before the clock rises.
	task automatic start;
		w(1);
		sda_oe_o <= 1'b0;
		w(8);
		scl_o <= 1'b1;
		w(10);
		sda_oe_o <= 1'b1;
		w(10);
		scl_o <= 1'b0;
		w(2);
	endtask

	task automatic stop;
		w(2);
		sda_oe_o <= 1'b1;
		w(8);
		scl_o <= 1'b1;
		w(10);
		sda_oe_o <= 1'b0;
		w(10);
		#1;
	endtask

	task automatic bit_x(input logic b, output logic r);
		w(2);
		sda_oe_o <= !b;
		w(4);
		scl_o <= 1'b1;
		w(2);
		r = sda_i;
		scl_o <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], a);
		end
		bit_x(1'b1, a);
	endtask

	task automatic rd(input logic last, output logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, a);
			d[i] = a;
		end
		bit_x(last, a);
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the thermal alert sensor with a host model.
// Assumes pull-ups on the data and alert wires, modelled here.
`timescale 1ns/1ns
`include "tas_params.svh"
module tb_top;
	import tas_pkg::*;
	localparam int C = 20;
	localparam logic [7:0] AW = {`TAS_ADDR_HIGH, 3'h5, 1'b0};
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic scl, h_oe, d_oe, d_o, a_oe, a_o, ak, ok;
	logic [2:0] sel = 3'h5;
	tas_temp_t temp = 11'h100;
	wire sda = !(h_oe | d_oe);
	wire alert = !a_oe;
	int num_errors = 0;
	int comparisons = 0;
	logic [15:0] rv;

	always #5 mclk_i = !mclk_i;

	tas_sensor #(.CONV_CYCLES(C)) i_tas_sensor (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(d_o), .sda_oe_o(d_oe), .addr_sel_i(sel), .temp_sample_i(temp),
		.overtemp_alert_output_o(a_o), .overtemp_alert_output_oe_o(a_oe));
	tas_i2c_host i_tas_i2c_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

	// ==========
	// Helpers
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chkb(input logic g, input logic e);
		chk({15'h0, g}, {15'h0, e});
	endtask
	task end_of_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task set_t(input tas_temp_t v);
		@(posedge mclk_i);
		temp <= v;
	endtask
	// A level that never comes counts as a mismatch and closes the run.
	task wal(input logic lv, input int lim, output int n);
		n = 0;
		while (alert !== lv) begin
			w(1);
			n++;
			if (n > lim) begin
				chkb(alert, lv);
				end_of_test;
			end
		end
	endtask
	task xw(input logic [7:0] p, input int nb, input logic [15:0] d);
		i_tas_i2c_host.start();
		i_tas_i2c_host.wr(AW, ak);
		chkb(ak, 1'b0);
		i_tas_i2c_host.wr(p, ak);
		for (int i = 0; i < nb; i++) begin
			i_tas_i2c_host.wr(d[15-8*i -: 8], ak);
		end
		i_tas_i2c_host.stop();
	endtask
	task xr(input logic sp, input logic [7:0] p, input int nb, output logic [15:0] d);
		logic [7:0] b;
		d = '0;
		if (sp) begin
			i_tas_i2c_host.start();
			i_tas_i2c_host.wr(AW, ak);
			i_tas_i2c_host.wr(p, ak);
		end
		i_tas_i2c_host.start();
		i_tas_i2c_host.wr(AW | 8'h01, ak);
		chkb(ak, 1'b0);
		for (int i = 0; i < nb; i++) begin
			i_tas_i2c_host.rd(i == nb - 1, b, ak);
			d[15-8*i -: 8] = b;
		end
		chkb(ak, 1'b1);
		i_tas_i2c_host.stop();
	endtask

	// ==========
	// Scenarios
	task t_reset;
		xr(1'b0, 8'h00, 2, rv);
		chk(rv, 16'h2000);
		xr(1'b1, `TAS_PTR_TOS, 2, rv);
		chk(rv, 16'h5000);
		xr(1'b1, `TAS_PTR_THYST, 2, rv);
		chk(rv, 16'h4b00);
		xr(1'b1, `TAS_PTR_CONF, 1, rv);
		chk(rv, 16'h0000);
		chkb(alert, 1'b1);
		$display("reset test done");
	endtask
	task t_comp;
		int n;
		set_t(11'h283);
		w(4*C);
		chkb(alert, 1'b1);
		set_t(11'h2a0);
		wal(1'b0, 3*C, n);
		set_t(11'h270);
		w(4*C);
		xr(1'b1, `TAS_PTR_TEMP, 2, rv);
		chk(rv, 16'h4e00);
		chkb(alert, 1'b0);
		xw(`TAS_PTR_CONF, 1, 16'h0100);
		chkb(alert, 1'b0);
		set_t(11'h100);
		w(4*C);
		chkb(alert, 1'b0);
		xr(1'b1, `TAS_PTR_TEMP, 2, rv);
		chk(rv, 16'h4e00);
		xw(`TAS_PTR_TOS, 2, 16'h5580);
		xr(1'b1, `TAS_PTR_TOS, 2, rv);
		chk(rv, 16'h5580);
		xw(`TAS_PTR_TOS, 2, 16'h5000);
		xw(`TAS_PTR_CONF, 1, 16'h0400);
		wal(1'b0, 4*C, n);
		xw(`TAS_PTR_CONF, 1, 16'h0000);
		chkb(alert, 1'b1);
		$display("comparator test done");
	endtask
	task t_fq;
		int n;
		int nq [4] = '{1, 2, 4, 6};
		for (int i = 0; i < 4; i++) begin
			xw(`TAS_PTR_CONF, 1, {3'h0, i[1:0], 11'h0});
			set_t(11'h2a0);
			wal(1'b0, 8*C, n);
			ok = n > (nq[i] - 1) * C && n <= nq[i] * C + 3;
			chkb(ok, 1'b1);
			set_t(11'h100);
			wal(1'b1, 8*C, n);
			ok = n > (nq[i] - 1) * C && n <= nq[i] * C + 3;
			chkb(ok, 1'b1);
		end
		$display("fault queue test done");
	endtask
	task t_int;
		int n;
		xw(`TAS_PTR_CONF, 1, 16'h0200);
		// An event latched while in comparator behaviour is dropped by this read first.
		xr(1'b0, 8'h00, 1, rv);
		chk(rv, 16'h0200);
		chkb(alert, 1'b1);
		set_t(11'h2a0);
		wal(1'b0, 3*C, n);
		xr(1'b0, 8'h00, 1, rv);
		chk(rv, 16'h0200);
		chkb(alert, 1'b1);
		w(4*C);
		chkb(alert, 1'b1);
		set_t(11'h100);
		wal(1'b0, 3*C, n);
		xw(`TAS_PTR_CONF, 1, 16'h0300);
		chkb(alert, 1'b1);
		xw(`TAS_PTR_CONF, 1, 16'h0000);
		$display("interrupt test done");
	endtask
	task t_bus;
		i_tas_i2c_host.start();
		i_tas_i2c_host.wr(AW ^ 8'h02, ak);
		chkb(ak, 1'b1);
		i_tas_i2c_host.stop();
		xr(1'b1, 8'h07, 2, rv);
		chk(rv, 16'h0000);
		xw(`TAS_PTR_TEMP, 2, 16'hffe0);
		xr(1'b1, `TAS_PTR_TEMP, 2, rv);
		chk(rv, 16'h2000);
		$display("bus test done");
	endtask

	initial begin
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		w(8);
		t_reset;
		t_comp;
		t_fq;
		t_int;
		t_bus;
		end_of_test;
	end
endmodule
